// File: hdl/led_cmd_regs.svh
// Constants of the serial command unit: field positions, reset values, counts.
// Assumes a 25 ns system clock; included by the command unit by bare name.
`ifndef LED_CMD_REGS_SVH
`define LED_CMD_REGS_SVH

// Shift register and channel count.
`define SHREG_W          16
`define SHREG_MSB        15

// Pulse counts while the command strobe is high.
`define CNT_ONOFF_A      4'h0
`define CNT_ONOFF_B      4'h1
`define CNT_MANUAL_A     4'h5
`define CNT_MANUAL_B     4'h6
`define CNT_WORD1_A      4'h7
`define CNT_WORD1_B      4'h8
`define CNT_WORD2_A      4'h9
`define CNT_WORD2_B      4'hA
`define CNT_MAX          4'hF

// State word one field positions.
`define W1_RANGE_BIT     15
`define W1_GAIN_HI       14
`define W1_GAIN_LO       8
`define W1_TEST_HI       7
`define W1_TEST_LO       4
`define W1_INIT_BIT      1
`define W1_STANDBY_BIT   0

// State word two field positions.
`define W2_OPEN_BIT      14
`define W2_SHORT_BIT     13

// Reset values: high range, gain code for 100 %, everything else normal.
`define W1_RESET         16'h2B00
`define W2_RESET         16'h0000
`define ONOFF_RESET      16'h0000
`define RESULT_NORMAL    16'hFFFF

// Timing: forced-current interval and least on-time for automatic detection.
`define CLK_PERIOD_NS    25
`define FORCE_NS         800
`define FORCE_CYC        ((`FORCE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define AUTO_MIN_NS      800
`define AUTO_CYC  (((`AUTO_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS) + 1)

`endif

// File: hdl/led_cmd_pkg.sv
// Types shared by the serial command unit.
// Assumes the constants header is compiled alongside.
package led_cmd_pkg;

  typedef enum logic [4:0] {
    CMD_NONE   = 5'h01,
    CMD_ONOFF  = 5'h02,
    CMD_MANUAL = 5'h04,
    CMD_WORD1  = 5'h08,
    CMD_WORD2  = 5'h10
  } cmd_e;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'h1,
    ST_FORCE = 2'h2
  } force_state_e;

  typedef struct packed {
    logic       range_select_bit;
    logic [6:0] gain_code;
    logic [3:0] test_bits;
    logic [1:0] unused_bits;
    logic       init_bit;
    logic       standby_one_bit;
  } state_word_one_s;

  typedef struct packed {
    logic        thermal_cutoff;
    logic        open_detect_enable_bit;
    logic        short_detect_enable_bit;
    logic [12:0] other_bits;
  } state_word_two_s;

  typedef struct packed {
    logic open_fault;
    logic short_fault;
  } fault_sense_s;

endpackage : led_cmd_pkg

// File: hdl/pin_sync.sv
// Two-stage synchroniser for a group of pin inputs.
// Assumes inputs are asynchronous to clk; the first stage feeds only the second.
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset.
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Data.
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1_r <= '0;
      sync_out <= '0;
    end else begin
      stage1_r <= async_in;
      sync_out <= stage1_r;
    end
  end

endmodule : pin_sync

// File: hdl/led_cmd_unit.sv
// Serial command front end of a 16-channel LED sink driver.
// Assumes all pin inputs are asynchronous to SYS_CLK; the shift clock is
// sampled and its edges found by SYS_CLK, so it must stay well below 20 MHz.
// The forced interval and the automatic on-time are counted in SYS_CLK
// cycles, so a different system clock needs new counts in the header.
// Standby is only reported; switching the analog part off is left outside.
//
// Operation
// - Serial data enters a 16-bit shift register; strobe plus clocks pick command.
// - Zero or one clock pulses under a high strobe latch on/off data.
// - Five or six pulses under a high strobe run manual fault detection.
// - Seven or eight pulses under a high strobe load state word one.
// - Nine or ten pulses under a high strobe load state word two.
// - Any other pulse count is ignored and does nothing.
// - On/off word MSB first, bit n drives channel n, default all off.
// - Blanking input high forces all channels off; low follows latched bits.
// - With detection on, the result is copied into the shift register.
// - Automatic check judges only channels on; off channels report normal.
// - On-time of 800 ns or less makes every channel report normal.
// - Automatic detection starts on the falling edge of the blanking input.
// - Result bit n belongs to channel n, shifted out MSB first.
// - Result bit is 0 for open or short fault, 1 for normal.
// - First clock after on/off latch with detection on loads the result, ignoring serial input.
// - Manual detection forces probe current 800 ns, then loads the result.
// - Manual detection skipped if blanking is low or detection disabled.
// - First clock after manual detection loads the result, ignoring input.
// - Word one command copies the shift register into state word one.
// - Word one: range bit 15, gain 14..8, test 7..4, init 1, standby 0.
// - Range 0 is high range and default; gain defaults to 100 percent.
// - Detection enables change only through word two or init; both off at reset.
// - Reset sets outputs off, high range, default gain, normal operation.
// - Init bit clears all data to defaults and returns to normal.
// - Standby keeps data and loads; an on/off latch leaves standby.
// - Word two command loads enables: open bit 14, short bit 13.
`timescale 1ns/1ps
`include "led_cmd_regs.svh"
module led_cmd_unit (
  // Clock and reset.
  input  wire logic                         SYS_CLK,
  input  wire logic                         RSTN,
  // Serial link from the controller.
  input  wire logic                         SERIAL_DATA_IN,
  input  wire logic                         SHIFT_CLK,
  input  wire logic                         COMMAND_STROBE,
  output logic                              SERIAL_DATA_OUT,
  // Output blanking pin, high forces channels off.
  input  wire logic                         OUTPUT_BLANK,
  // Fault comparators of each channel, high means fault seen.
  input  wire led_cmd_pkg::fault_sense_s [15:0] FAULT_SENSE,
  // Channel drive and probe current.
  output logic [15:0]                       CURRENT_SINK_CHANNELS,
  output logic                              PROBE_CURRENT_ON,
  // Decoded state to the analog part.
  output led_cmd_pkg::state_word_one_s      STATE_WORD_ONE,
  output led_cmd_pkg::state_word_two_s      STATE_WORD_TWO,
  output logic                              STANDBY_ACTIVE
);
  import led_cmd_pkg::*;

  logic [3:0]       ctl_sync;
  logic [31:0]      fault_sync;
  logic             sck_s;
  logic             strobe_s;
  logic             sdi_s;
  logic             blank_s;
  logic             sck_d_r;
  logic             strobe_d_r;
  logic             blank_d_r;
  logic             sck_rise;
  logic             strobe_fall;
  logic             blank_fall;
  logic [3:0]       pulse_cnt_r;
  cmd_e             cmd;
  logic             cmd_fire;
  logic [15:0]      shreg_r;
  logic [15:0]      onoff_r;
  state_word_one_s  word1_r;
  state_word_two_s  word2_r;
  logic             standby_r;
  logic             init_req;
  logic             det_en;
  logic [15:0]      fault_now;
  logic [15:0]      fault_result_word_r;
  logic             pending_r;
  force_state_e     fstate_r;
  logic [5:0]       force_cnt_r;
  logic             force_done;
  logic             manual_go;
  logic [5:0]       auto_cnt_r;
  logic             auto_capture;
  logic             onoff_latch;

  // Every pin except clock and reset goes through two flops before any logic looks at it.
  pin_sync #(.WIDTH(4)) u_ctl_sync (
    .clk      (SYS_CLK),
    .rst_n    (RSTN),
    .async_in ({SHIFT_CLK, COMMAND_STROBE, SERIAL_DATA_IN, OUTPUT_BLANK}),
    .sync_out (ctl_sync)
  );

  pin_sync #(.WIDTH(32)) u_fault_sync (
    .clk      (SYS_CLK),
    .rst_n    (RSTN),
    .async_in (FAULT_SENSE),
    .sync_out (fault_sync)
  );

  assign sck_s    = ctl_sync[3];
  assign strobe_s = ctl_sync[2];
  assign sdi_s    = ctl_sync[1];
  assign blank_s  = ctl_sync[0];

  // The edge registers reset to the synchronisers' low level, so a blanking
  // pin held low from power-on never reads as a falling edge.
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      sck_d_r    <= 1'b0;
      strobe_d_r <= 1'b0;
      blank_d_r  <= 1'b0;
    end else begin
      sck_d_r    <= sck_s;
      strobe_d_r <= strobe_s;
      blank_d_r  <= blank_s;
    end
  end

  assign sck_rise    = sck_s & ~sck_d_r;
  assign strobe_fall = ~strobe_s & strobe_d_r;
  assign blank_fall  = ~blank_s & blank_d_r;

  // Pulses are counted while the strobe is high and the count saturates,
  // so a long train cannot wrap around into a valid command code.
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      pulse_cnt_r <= 4'h0;
    end else if (strobe_fall) begin
      pulse_cnt_r <= 4'h0;
    end else if (strobe_s && sck_rise && pulse_cnt_r != `CNT_MAX) begin
      pulse_cnt_r <= pulse_cnt_r + 4'h1;
    end
  end

  always_comb begin
    case (pulse_cnt_r)
      `CNT_ONOFF_A, `CNT_ONOFF_B:   cmd = CMD_ONOFF;
      `CNT_MANUAL_A, `CNT_MANUAL_B: cmd = CMD_MANUAL;
      `CNT_WORD1_A, `CNT_WORD1_B:   cmd = CMD_WORD1;
      `CNT_WORD2_A, `CNT_WORD2_B:   cmd = CMD_WORD2;
      default:                      cmd = CMD_NONE;
    endcase
  end

  assign cmd_fire    = strobe_fall;
  assign onoff_latch = cmd_fire && cmd == CMD_ONOFF;
  assign det_en      = word2_r.open_detect_enable_bit |
                       word2_r.short_detect_enable_bit;
  assign init_req    = cmd_fire && cmd == CMD_WORD1 &&
                       shreg_r[`W1_INIT_BIT];
  assign manual_go   = cmd_fire && cmd == CMD_MANUAL && det_en &&
                       blank_s && fstate_r == ST_IDLE;

  // Per channel fault: any enabled comparator firing, whether the channel is on or off.
  genvar ch;
  generate
    for (ch = 0; ch < 16; ch++) begin : g_fault
      logic open_seen;
      logic short_seen;
      assign open_seen  = fault_sync[2*ch+1] &
                          word2_r.open_detect_enable_bit;
      assign short_seen = fault_sync[2*ch] &
                          word2_r.short_detect_enable_bit;
      assign fault_now[ch] = ~(open_seen | short_seen);
    end
  endgenerate

  // On/off latch; init returns it to all off.
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      onoff_r <= `ONOFF_RESET;
    end else if (init_req) begin
      onoff_r <= `ONOFF_RESET;
    end else if (onoff_latch) begin
      onoff_r <= shreg_r;
    end
  end

  // State words and standby.
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      word1_r   <= `W1_RESET;
      word2_r   <= `W2_RESET;
      standby_r <= 1'b0;
    end else if (init_req) begin
      word1_r   <= `W1_RESET;
      word2_r   <= `W2_RESET;
      standby_r <= 1'b0;
    end else if (cmd_fire) begin
      case (cmd)
        CMD_ONOFF: begin
          standby_r <= 1'b0;
        end
        CMD_WORD1: begin
          word1_r   <= shreg_r;
          standby_r <= shreg_r[`W1_STANDBY_BIT];
        end
        CMD_WORD2: begin
          word2_r <= shreg_r;
        end
        default: begin
          standby_r <= standby_r;
        end
      endcase
    end
  end

  // Manual detection: probe current for the forced interval, then capture.
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      fstate_r    <= ST_IDLE;
      force_cnt_r <= 6'h00;
    end else begin
      case (fstate_r)
        ST_IDLE: begin
          if (manual_go) begin
            fstate_r    <= ST_FORCE;
            force_cnt_r <= 6'h01;
          end
        end
        ST_FORCE: begin
          if (force_done || init_req) begin
            fstate_r    <= ST_IDLE;
            force_cnt_r <= 6'h00;
          end else begin
            force_cnt_r <= force_cnt_r + 6'h01;
          end
        end
        default: begin
          fstate_r    <= ST_IDLE;
          force_cnt_r <= 6'h00;
        end
      endcase
    end
  end

  // The capture edge is the last edge of the forced interval, while the
  // probe current still flows into the outputs.
  assign force_done = fstate_r == ST_FORCE &&
                      force_cnt_r == 6'(`FORCE_CYC);

  // Automatic detection timer, started only by the blanking falling edge.
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      auto_cnt_r <= 6'h00;
    end else if (blank_s) begin
      auto_cnt_r <= 6'h00;
    end else if (blank_fall) begin
      auto_cnt_r <= 6'h01;
    end else if (auto_cnt_r != 6'h00 && auto_cnt_r != 6'h3F) begin
      auto_cnt_r <= auto_cnt_r + 6'h01;
    end
  end

  // Capture only after more than the least on-time has passed.
  assign auto_capture = det_en && !blank_s &&
                        auto_cnt_r == 6'(`AUTO_CYC);

  // Result word: invalid pulses read all normal, off channels read normal after automatic checks.
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      fault_result_word_r <= `RESULT_NORMAL;
    end else if (init_req) begin
      fault_result_word_r <= `RESULT_NORMAL;
    end else if (force_done) begin
      fault_result_word_r <= fault_now;
    end else if (blank_fall) begin
      fault_result_word_r <= `RESULT_NORMAL;
    end else if (auto_capture) begin
      fault_result_word_r <= fault_now | ~onoff_r;
    end
  end

  // One pending load of the result into the shift register. A new arm wins
  // over the clear so a latch landing on a clock edge is not lost.
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      pending_r <= 1'b0;
    end else if (init_req) begin
      pending_r <= 1'b0;
    end else if ((onoff_latch && det_en) || force_done) begin
      pending_r <= 1'b1;
    end else if (sck_rise && !strobe_s) begin
      pending_r <= 1'b0;
    end
  end

  // Shift register. Clocks under a high strobe only count, they do not shift.
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      shreg_r <= 16'h0000;
    end else if (init_req) begin
      shreg_r <= 16'h0000;
    end else if (force_done) begin
      shreg_r <= fault_now;
    end else if (sck_rise && !strobe_s) begin
      if (pending_r) begin
        shreg_r <= fault_result_word_r;
      end else begin
        shreg_r <= {shreg_r[14:0], sdi_s};
      end
    end
  end

  // The probe output rises on the edge that starts the forced interval and
  // falls on the capture edge, so it stands for the whole interval. An init
  // word aborts it together with the interval.
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      PROBE_CURRENT_ON <= 1'b0;
    end else if (manual_go) begin
      PROBE_CURRENT_ON <= 1'b1;
    end else if (force_done || init_req) begin
      PROBE_CURRENT_ON <= 1'b0;
    end
  end

  // Registered outputs.
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      CURRENT_SINK_CHANNELS <= 16'h0000;
      SERIAL_DATA_OUT       <= 1'b0;
    end else begin
      CURRENT_SINK_CHANNELS <= onoff_r & {16{~blank_s}};
      SERIAL_DATA_OUT       <= shreg_r[`SHREG_MSB];
    end
  end

  assign STATE_WORD_ONE = word1_r;
  assign STATE_WORD_TWO = word2_r;
  assign STANDBY_ACTIVE = standby_r;

endmodule : led_cmd_unit

// File: verif/led_ctrl_model.sv
// Behavioural model of the controller that drives the serial pins.
// Assumes the caller enters its tasks at a falling edge of sys_clk.
`timescale 1ns/1ps
module led_ctrl_model (
  // Clock and returned data.
  input  wire logic sys_clk,
  input  wire logic sdo,
  // Serial pins and blanking.
  output logic      sdi,
  output logic      sck,
  output logic      strobe,
  output logic      blank
);
  initial begin
    sdi    = 1'b0;
    sck    = 1'b0;
    strobe = 1'b0;
    blank  = 1'b1;
  end

  task automatic wait_cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : wait_cyc

  task automatic set_blank(input logic v);
    blank = v;
    wait_cyc(6);
  endtask : set_blank

  // The link clock stays low outside frames; 200 ns period.
  task automatic pulse();
    sck = 1'b1;
    wait_cyc(4);
    sck = 1'b0;
    wait_cyc(4);
  endtask : pulse

  task automatic xfer(input logic [15:0] w, output logic [15:0] got);
    for (int i = 15; i >= 0; i--) begin
      got[i] = sdo;
      sdi = w[i];
      wait_cyc(2);
      pulse();
    end
    // A released data line shows the inverse so no stale level passes.
    sdi = ~sdi;
  endtask : xfer

  task automatic cmd(input int n);
    strobe = 1'b1;
    wait_cyc(2);
    repeat (n) pulse();
    wait_cyc(2);
    strobe = 1'b0;
    wait_cyc(6);
  endtask : cmd

  // No shift clocks while the probe current flows.
  task automatic manual(input int n);
    cmd(n);
    wait_cyc(40);
  endtask : manual
endmodule : led_ctrl_model

// File: verif/led_cmd_unit_checker.sv
// Concurrent checks on the ports of the serial command unit.
// Assumes it is bound into every instance of the unit.
`timescale 1ns/1ps
module led_cmd_unit_checker (
  // Clock and reset.
  input wire logic                        SYS_CLK,
  input wire logic                        RSTN,
  // Pins.
  input wire logic                        SHIFT_CLK,
  input wire logic                        COMMAND_STROBE,
  input wire logic                        SERIAL_DATA_OUT,
  input wire logic                        OUTPUT_BLANK,
  input wire logic [15:0]                 CURRENT_SINK_CHANNELS,
  input wire logic                        PROBE_CURRENT_ON,
  // State.
  input wire led_cmd_pkg::state_word_one_s STATE_WORD_ONE,
  input wire led_cmd_pkg::state_word_two_s STATE_WORD_TWO,
  input wire logic                        STANDBY_ACTIVE
);
  import led_cmd_pkg::*;
  logic [5:0] probe_cnt_r;
  logic [3:0] idle_age_r;

  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RSTN);

  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) probe_cnt_r <= 6'h00;
    else if (PROBE_CURRENT_ON) probe_cnt_r <= probe_cnt_r + 6'h01;
    else probe_cnt_r <= 6'h00;
  end

  // The serial output may only move shortly after link activity.
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) idle_age_r <= 4'h0;
    else if (SHIFT_CLK || COMMAND_STROBE || PROBE_CURRENT_ON) idle_age_r <= 4'h0;
    else if (idle_age_r != 4'hF) idle_age_r <= idle_age_r + 4'h1;
  end

  reset_default_a: assert property (
    !$past(RSTN) |-> STATE_WORD_ONE == 16'h2B00 && STATE_WORD_TWO == 16'h0000
      && CURRENT_SINK_CHANNELS == 16'h0000) else $error("reset values wrong");
  blank_off_a: assert property (
    OUTPUT_BLANK [*4] |=> CURRENT_SINK_CHANNELS == 16'h0000)
    else $error("channel on while blanked");
  probe_len_a: assert property (
    $fell(PROBE_CURRENT_ON) |-> probe_cnt_r == 6'h20)
    else $error("probe interval not 32 cycles");
  probe_enable_a: assert property (
    $rose(PROBE_CURRENT_ON) |-> STATE_WORD_TWO.open_detect_enable_bit
      || STATE_WORD_TWO.short_detect_enable_bit)
    else $error("probe without detection enabled");
  word_timing_a: assert property (
    $changed({STATE_WORD_ONE, STATE_WORD_TWO}) |-> $past(COMMAND_STROBE, 3)
      || $past(COMMAND_STROBE, 4) || $past(COMMAND_STROBE, 5))
    else $error("state word changed without strobe fall");
  sdo_quiet_a: assert property (
    $changed(SERIAL_DATA_OUT) |-> idle_age_r <= 4'h6)
    else $error("serial output moved while link idle");
  standby_set_a: assert property (
    $rose(STANDBY_ACTIVE) |-> STATE_WORD_ONE.standby_one_bit)
    else $error("standby without standby bit");
  init_clear_a: assert property (
    STATE_WORD_ONE.init_bit == 1'b0) else $error("init bit stored");

  cover property ($rose(PROBE_CURRENT_ON));
  cover property ($rose(STANDBY_ACTIVE));
  cover property ($changed(STATE_WORD_TWO));
endmodule : led_cmd_unit_checker

bind led_cmd_unit led_cmd_unit_checker chk_u (
  .SYS_CLK(SYS_CLK), .RSTN(RSTN), .SHIFT_CLK(SHIFT_CLK),
  .COMMAND_STROBE(COMMAND_STROBE), .SERIAL_DATA_OUT(SERIAL_DATA_OUT),
  .OUTPUT_BLANK(OUTPUT_BLANK), .CURRENT_SINK_CHANNELS(CURRENT_SINK_CHANNELS),
  .PROBE_CURRENT_ON(PROBE_CURRENT_ON), .STATE_WORD_ONE(STATE_WORD_ONE),
  .STATE_WORD_TWO(STATE_WORD_TWO), .STANDBY_ACTIVE(STANDBY_ACTIVE)
);

// File: verif/led_cmd_unit_bench.sv
// Self-checking bench of the serial command unit with a controller model.
// Assumes the model drives pins at falling edges of the system clock.
`timescale 1ns/1ps
module led_cmd_unit_bench;
  import led_cmd_pkg::*;
  logic                  sys_clk, rstn, sdi, sck, strobe, blank;
  logic                  sdo, probe_on, stby, probe_q;
  logic [15:0]           chan, got;
  fault_sense_s [15:0]   fault;
  state_word_one_s       w1;
  state_word_two_s       w2;
  int                    n_fail, num_checks, cycles, probe_rises;

  led_cmd_unit dut_u (
    .SYS_CLK(sys_clk), .RSTN(rstn), .SERIAL_DATA_IN(sdi),
    .SHIFT_CLK(sck), .COMMAND_STROBE(strobe), .SERIAL_DATA_OUT(sdo),
    .OUTPUT_BLANK(blank), .FAULT_SENSE(fault),
    .CURRENT_SINK_CHANNELS(chan), .PROBE_CURRENT_ON(probe_on),
    .STATE_WORD_ONE(w1), .STATE_WORD_TWO(w2), .STANDBY_ACTIVE(stby)
  );
  led_ctrl_model ctl_u (
    .sys_clk(sys_clk), .sdo(sdo), .sdi(sdi), .sck(sck),
    .strobe(strobe), .blank(blank)
  );

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  task automatic chk16(input string what, input logic [15:0] exp,
                       input logic [15:0] seen);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk16

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : wrap_up

  // Cycle ceiling is several times the expected run length.
  always @(negedge sys_clk) begin
    probe_q <= probe_on;
    if (probe_on === 1'b1 && probe_q === 1'b0) probe_rises++;
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      wrap_up();
    end
  end

  task automatic t_onoff();
    logic [15:0] pat [2] = '{16'hA5C3, 16'h3C81};
    ctl_u.set_blank(1'b0);
    for (int n = 0; n < 2; n++) begin
      ctl_u.xfer(pat[n], got);
      ctl_u.cmd(n);
      chk16("channels", pat[n], chan);
    end
    ctl_u.set_blank(1'b1);
    chk16("blanked", 16'h0000, chan);
  endtask : t_onoff

  task automatic t_bad();
    int bad [5] = '{2, 3, 4, 11, 15};
    ctl_u.set_blank(1'b0);
    ctl_u.xfer(16'h1234, got);
    chk16("shift out", 16'h3C81, got);
    foreach (bad[i]) ctl_u.cmd(bad[i]);
    chk16("channels", 16'h3C81, chan);
    chk16("word one", 16'h2B00, w1);
    chk16("word two", 16'h0000, w2);
    ctl_u.xfer(16'h0000, got);
    chk16("shift kept", 16'h1234, got);
    ctl_u.set_blank(1'b1);
  endtask : t_bad

  task automatic t_word1();
    ctl_u.xfer(16'h9D01, got);
    ctl_u.cmd(7);
    chk16("word one", 16'h9D01, w1);
    chk16("standby", 16'h0001, {15'h0000, stby});
    ctl_u.cmd(0);
    chk16("standby", 16'h0000, {15'h0000, stby});
    ctl_u.xfer(16'h8002, got);
    ctl_u.cmd(8);
    chk16("word one", 16'h2B00, w1);
    ctl_u.set_blank(1'b0);
    chk16("channels", 16'h0000, chan);
    ctl_u.set_blank(1'b1);
  endtask : t_word1

  task automatic auto_run(input int low_cyc, input logic [15:0] exp);
    ctl_u.cmd(0);
    ctl_u.set_blank(1'b0);
    ctl_u.wait_cyc(low_cyc);
    ctl_u.set_blank(1'b1);
    ctl_u.pulse();
    ctl_u.xfer(16'h00FF, got);
    chk16("auto result", exp, got);
  endtask : auto_run

  // Channel 3 sees an open, channel 10 a short.
  task automatic t_detect();
    int n;
    fault[3].open_fault = 1'b1;
    fault[10].short_fault = 1'b1;
    ctl_u.xfer(16'h6000, got);
    ctl_u.cmd(9);
    chk16("word two", 16'h6000, w2);
    n = probe_rises;
    ctl_u.manual(6);
    chk16("probes", 16'h0001, 16'(probe_rises - n));
    ctl_u.pulse();
    ctl_u.xfer(16'h00FF, got);
    chk16("manual result", 16'hFBF7, got);
    ctl_u.set_blank(1'b0);
    ctl_u.manual(5);
    chk16("probes", 16'h0001, 16'(probe_rises - n));
    ctl_u.set_blank(1'b1);
    fault = '1;
    ctl_u.manual(5);
    chk16("probes", 16'h0002, 16'(probe_rises - n));
    ctl_u.pulse();
    ctl_u.xfer(16'h00FF, got);
    chk16("all faults", 16'h0000, got);
    fault = '0;
    fault[3].open_fault = 1'b1;
    fault[10].short_fault = 1'b1;
    auto_run(50, 16'hFFF7);
    auto_run(20, 16'hFFFF);
    ctl_u.xfer(16'h4000, got);
    ctl_u.cmd(10);
    chk16("word two", 16'h4000, w2);
    ctl_u.manual(6);
    ctl_u.pulse();
    ctl_u.xfer(16'h00FF, got);
    chk16("open only", 16'hFFF7, got);
  endtask : t_detect

  // A reset in mid-run must bring back the power-on state.
  task automatic t_reset();
    rstn = 1'b0;
    ctl_u.wait_cyc(3);
    rstn = 1'b1;
    ctl_u.wait_cyc(4);
    chk16("word two", 16'h0000, w2);
    chk16("channels", 16'h0000, chan);
    ctl_u.xfer(16'h5AA5, got);
    chk16("shift reset", 16'h0000, got);
  endtask : t_reset

  initial begin
    rstn = 1'b0;
    fault = '0;
    n_fail = 0;
    num_checks = 0;
    cycles = 0;
    probe_rises = 0;
    repeat (3) @(negedge sys_clk);
    rstn = 1'b1;
    repeat (4) @(negedge sys_clk);
    chk16("channels", 16'h0000, chan);
    chk16("word one", 16'h2B00, w1);
    chk16("word two", 16'h0000, w2);
    chk16("standby", 16'h0000, {15'h0000, stby});
    t_onoff();
    t_bad();
    t_word1();
    t_detect();
    t_reset();
    wrap_up();
  end
endmodule : led_cmd_unit_bench
